// ---- hdl/rcmd_defs.svh ----
`ifndef RCMD_DEFS_SVH
`define RCMD_DEFS_SVH

// factors are held in half units: 5 means 2.5
// five bits: a core factor of 8 needs 16 halves
`define RCMD_FACTOR_W 5
`define RCMD_CODE_W 7
`define RCMD_UPPER_W 4
`define RCMD_PIN_W 3
// extended table, first block: 33 MHz input
`define RCMD_EXT_LO_FIRST 7'h08
`define RCMD_EXT_LO_LAST 7'h20
`define RCMD_EXT_LO_CORE_STEPS 3'h5
`define RCMD_EXT_LO_CPM_BASE 5'h04
`define RCMD_EXT_LO_CORE_BASE 5'h08
// reserved gap
`define RCMD_RSV_FIRST 7'h21
`define RCMD_RSV_LAST 7'h2c
// extended table, second block: 66 MHz input
`define RCMD_EXT_HI_FIRST 7'h2d
`define RCMD_EXT_HI_LAST 7'h44
`define RCMD_EXT_HI_CORE_STEPS 3'h6
`define RCMD_EXT_HI_CPM_BASE 5'h04
`define RCMD_EXT_HI_CORE_BASE 5'h04
// factor steps in half units
`define RCMD_STEP_WHOLE 5'h02
`define RCMD_STEP_HALF 5'h01
// reset values of the factors: basic code 000
`define RCMD_RST_CPM 5'h06
`define RCMD_RST_CORE 5'h08

`endif

// ---- hdl/rcmd_pkg.sv ----
package rcmd_pkg;
  `include "rcmd_defs.svh"

  typedef enum logic [2:0] {
    RCMD_LOCAL = 3'h1,
    RCMD_BRIDGE_HOST = 3'h2,
    RCMD_BRIDGE_AGENT = 3'h4
  } rcmd_clkmode_t;

  typedef enum logic [1:0] {
    RCMD_WAIT_POR = 2'h1,
    RCMD_RUN = 2'h2
  } rcmd_state_t;

  typedef struct packed {
    rcmd_state_t state;
    logic [`RCMD_CODE_W-1:0] code;
    logic [`RCMD_FACTOR_W-1:0] cpmFactor;
    logic [`RCMD_FACTOR_W-1:0] coreFactor;
    logic reserved;
    rcmd_clkmode_t clockMode;
    logic bridgeRangeLow;
  } rcmd_regs_t;
endpackage

// ---- hdl/rcmd_decoder.sv ----
`timescale 1ns/1ps
`include "rcmd_defs.svh"
// How it works
// - sample three mode pins during hard reset
// - new configuration only applies after power-on reset
// - 33 MHz basic codes: fixed factor table
// - 66 MHz basic codes: fixed factor table
// - strap adds four upper bits above pins
// - extended low block steps; gap is reserved
// - extended high block steps in half units
// - bridge strap picks local, host or agent
// - bridge mode takes bits from local lines
module rcmd_decoder
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEnable,
  input wire logic power_on_reset,
  input wire logic hard_reset,
  input wire logic [2:0] clock_mode_select,
  input wire logic reset_config_strap,
  input wire logic [3:0] clock_mode_upper_bits,
  input wire logic bridge_clock_select,
  input wire logic bridge_role_select,
  input wire logic bridge_clock_range_select,
  input wire logic local_gp_line_0,
  input wire logic local_gp_line_1,
  input wire logic local_gp_line_2,
  input wire logic local_gp_line_3,
  input wire logic local_gp_line_5,
  output rcmd_pkg::rcmd_clkmode_t clockMode,
  output logic [6:0] modeCode,
  output logic [`RCMD_FACTOR_W-1:0] cpmFactorHalves,
  output logic [`RCMD_FACTOR_W-1:0] coreFactorHalves,
  output logic reservedCode,
  output logic bridgeRangeLow,
  output logic configValid
);
  import rcmd_pkg::*;

  rcmd_regs_t regs;
  rcmd_regs_t next_regs;
  logic [`RCMD_UPPER_W-1:0] upperBits;
  logic [`RCMD_CODE_W-1:0] sampledCode;
  logic rangeBit;
  rcmd_clkmode_t sampledMode;
  logic [`RCMD_FACTOR_W-1:0] decCpm;
  logic [`RCMD_FACTOR_W-1:0] decCore;
  logic decReserved;
  logic [`RCMD_CODE_W-1:0] offset;
  logic [`RCMD_CODE_W-1:0] stepIdx;
  logic [2:0] coreIdx;

  // ----------------------------------------------------------------
  // strap sources
  // ----------------------------------------------------------------
  always_comb
  begin
    if (bridge_clock_select)
    begin
      sampledMode = RCMD_LOCAL;
    end
    else if (bridge_role_select)
    begin
      sampledMode = RCMD_BRIDGE_AGENT;
    end
    else
    begin
      sampledMode = RCMD_BRIDGE_HOST;
    end
    // bridge modes reuse local lines; local mode keeps dedicated straps
    if (sampledMode != RCMD_LOCAL)
    begin
      upperBits = {local_gp_line_0, local_gp_line_1, local_gp_line_2, local_gp_line_3};
      rangeBit = local_gp_line_5;
    end
    else
    begin
      upperBits = clock_mode_upper_bits;
      rangeBit = bridge_clock_range_select;
    end
    // upper bits only count in the extended sequence
    if (reset_config_strap)
    begin
      sampledCode = {upperBits, clock_mode_select};
    end
    else
    begin
      sampledCode = {4'h0, clock_mode_select};
    end
  end

  // ----------------------------------------------------------------
  // factor decode, half units
  // ----------------------------------------------------------------
  always_comb
  begin
    decCpm = `RCMD_RST_CPM;
    decCore = `RCMD_RST_CORE;
    decReserved = 1'b0;
    offset = 7'h00;
    stepIdx = 7'h00;
    coreIdx = 3'h0;
    if (sampledCode < `RCMD_EXT_LO_FIRST)
    begin
      // basic codes: upper bits zero
      case (sampledCode[2:0])
        3'h0:
        begin
          decCpm = 5'h06;
          decCore = 5'h08;
        end
        3'h1:
        begin
          decCpm = 5'h06;
          decCore = 5'h0a;
        end
        3'h2:
        begin
          decCpm = 5'h08;
          decCore = 5'h08;
        end
        3'h3:
        begin
          decCpm = 5'h08;
          decCore = 5'h0a;
        end
        3'h4:
        begin
          decCpm = 5'h04;
          decCore = 5'h05;
        end
        3'h5:
        begin
          decCpm = 5'h04;
          decCore = 5'h06;
        end
        3'h6:
        begin
          decCpm = 5'h05;
          decCore = 5'h05;
        end
        default:
        begin
          decCpm = 5'h05;
          decCore = 5'h06;
        end
      endcase
    end
    else if (sampledCode <= `RCMD_EXT_LO_LAST)
    begin
      offset = sampledCode - `RCMD_EXT_LO_FIRST;
      stepIdx = offset / 7'(`RCMD_EXT_LO_CORE_STEPS);
      coreIdx = 3'(offset % 7'(`RCMD_EXT_LO_CORE_STEPS));
      decCpm = `RCMD_EXT_LO_CPM_BASE + 5'(stepIdx) * `RCMD_STEP_WHOLE;
      decCore = `RCMD_EXT_LO_CORE_BASE + 5'(coreIdx) * `RCMD_STEP_WHOLE;
    end
    else if (sampledCode <= `RCMD_RSV_LAST)
    begin
      decReserved = 1'b1;
    end
    else if (sampledCode <= `RCMD_EXT_HI_LAST)
    begin
      offset = sampledCode - `RCMD_EXT_HI_FIRST;
      stepIdx = offset / 7'(`RCMD_EXT_HI_CORE_STEPS);
      coreIdx = 3'(offset % 7'(`RCMD_EXT_HI_CORE_STEPS));
      decCpm = `RCMD_EXT_HI_CPM_BASE + 5'(stepIdx) * `RCMD_STEP_HALF;
      decCore = `RCMD_EXT_HI_CORE_BASE + 5'(coreIdx) * `RCMD_STEP_HALF;
    end
    else
    begin
      // above the table: no defined ratio
      decReserved = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // latch and hold
  // ----------------------------------------------------------------
  always_comb
  begin
    next_regs = regs;
    case (regs.state)
      RCMD_WAIT_POR:
      begin
        // resample while hard reset is held; run once both resets are released
        if (hard_reset)
        begin
          next_regs.code = sampledCode;
          next_regs.cpmFactor = decCpm;
          next_regs.coreFactor = decCore;
          next_regs.reserved = decReserved;
          next_regs.clockMode = sampledMode;
          next_regs.bridgeRangeLow = (sampledMode != RCMD_LOCAL) && rangeBit;
        end
        else if (!power_on_reset)
        begin
          next_regs.state = RCMD_RUN;
        end
      end
      RCMD_RUN:
      begin
        // hard reset alone does not reload ratios
        if (power_on_reset)
        begin
          next_regs.state = RCMD_WAIT_POR;
        end
      end
      default:
      begin
        next_regs.state = RCMD_WAIT_POR;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regs <= '{state: RCMD_WAIT_POR, code: 7'h00, cpmFactor: `RCMD_RST_CPM,
                coreFactor: `RCMD_RST_CORE, reserved: 1'b0, clockMode: RCMD_LOCAL,
                bridgeRangeLow: 1'b0};
    end
    else if (clockEnable)
    begin
      regs <= next_regs;
    end
  end

  assign clockMode = regs.clockMode;
  assign modeCode = regs.code;
  assign cpmFactorHalves = regs.cpmFactor;
  assign coreFactorHalves = regs.coreFactor;
  assign reservedCode = regs.reserved;
  assign bridgeRangeLow = regs.bridgeRangeLow;
  assign configValid = (regs.state == RCMD_RUN);
endmodule

// ---- verification/rcmd_assertions.sv ----
`timescale 1ns/1ps
module rcmd_checker
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEnable,
  input wire logic power_on_reset,
  input wire logic hard_reset,
  input wire logic reset_config_strap,
  input wire logic [6:0] modeCode,
  input wire logic [4:0] cpmFactorHalves,
  input wire logic [4:0] coreFactorHalves,
  input wire logic reservedCode,
  input wire logic configValid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_code_held: assert property (configValid && !power_on_reset |=> $stable(modeCode))
    else $error("code moved");
  a_upper_zero: assert property (clockEnable && hard_reset && !configValid &&
    !reset_config_strap |=> modeCode[6:3] == 0) else $error("upper bits");
  a_reserved_flag: assert property (reservedCode == (modeCode > 7'h44 ||
    modeCode inside {[7'h21:7'h2c]})) else $error("reserved flag");
  a_reserved_keep: assert property (reservedCode |-> cpmFactorHalves == 6 &&
    coreFactorHalves == 8) else $error("reserved factors");
  a_basic_cpm: assert property (modeCode < 8 |-> cpmFactorHalves == (modeCode[2] ?
    4'h4 + modeCode[1] : 4'h6 + {modeCode[1], 1'b0})) else $error("basic cpm");
  a_basic_core: assert property (modeCode < 8 |-> coreFactorHalves == (modeCode[2] ?
    4'h5 + modeCode[0] : 4'h8 + {modeCode[0], 1'b0})) else $error("basic core");
  a_valid_late: assert property ($rose(configValid) |->
    !$past(power_on_reset) && !$past(hard_reset)) else $error("early valid");
  a_por_drop: assert property (clockEnable && power_on_reset && configValid |=>
    !configValid) else $error("valid kept");
  cover property ($rose(configValid));
  cover property (reservedCode);
  cover property (modeCode > 7'h2c && configValid);
endmodule
bind rcmd_decoder rcmd_checker i_chk (.*);

// ---- verification/rcmd_straps.sv ----
`timescale 1ns/1ps
module rcmd_straps
(
  input wire logic [6:0] code,
  input wire logic bridge_clock_select,
  output logic [2:0] clock_mode_select,
  output logic [3:0] clock_mode_upper_bits,
  output logic [3:0] gpUpper
);
  // the idle source shows the inverse, so a wrong pick cannot pass
  assign clock_mode_select = code[2:0];
  assign clock_mode_upper_bits = code[6:3] ^ {4{!bridge_clock_select}};
  assign gpUpper = code[6:3] ^ {4{bridge_clock_select}};
endmodule

// ---- verification/rcmd_decoder_test.sv ----
`timescale 1ns/1ps
module rcmd_decoder_test;
  import rcmd_pkg::*;
  logic clock, rst_n, clockEnable, power_on_reset, hard_reset, reset_config_strap, lastValid;
  logic bridge_clock_select, bridge_role_select, bridge_clock_range_select, local_gp_line_5;
  logic local_gp_line_0, local_gp_line_1, local_gp_line_2, local_gp_line_3, reservedCode;
  logic [3:0] clock_mode_upper_bits, gpUpper;
  logic [4:0] cpmFactorHalves, coreFactorHalves;
  logic [6:0] code, modeCode;
  logic [2:0] clock_mode_select;
  logic bridgeRangeLow, configValid;
  rcmd_clkmode_t clockMode;
  logic [21:0] e, got, q[$];
  logic [31:0] rnd = 32'h0001_0818;
  int numErrors, checkCount, cycles;
  assign {local_gp_line_0, local_gp_line_1, local_gp_line_2, local_gp_line_3} = gpUpper;
  assign got = {modeCode, cpmFactorHalves, coreFactorHalves, reservedCode, clockMode,
    bridgeRangeLow};
  rcmd_straps i_brd (.*);
  rcmd_decoder i_dut (.*);
  initial
  begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  function automatic logic [10:0] expF(input logic [6:0] c);
    if (c < 8)
      return {c[2] ? 5'h04 + c[1] : 5'h06 + {c[1], 1'b0},
        c[2] ? 5'h05 + c[0] : 5'h08 + {c[0], 1'b0}, 1'b0};
    if (c < 7'h21)
      return {5'(4 + (c - 8) / 5 * 2), 5'(8 + (c - 8) % 5 * 2), 1'b0};
    if (c > 7'h2c && c < 7'h45)
      return {5'(4 + (c - 45) / 6), 5'(4 + (c - 45) % 6), 1'b0};
    return {5'h06, 5'h08, 1'b1};
  endfunction
  task automatic chk(input string n, input logic [21:0] x, input logic [21:0] g);
    checkCount++;
    numErrors += int'(g !== x);
    if (g !== x)
      $display("unexpected %s expected %h seen %h", n, x, g);
  endtask
  // p low repeats the old expectation: a resample without power-on changes nothing
  // a frozen clock enable repeats it as well
  task automatic cfg(input logic [6:0] c, input logic s, input logic [2:0] b, input logic p);
    logic [6:0] m;
    m = s ? c : {4'h0, c[2:0]};
    @(posedge clock) #1;
    {power_on_reset, hard_reset, reset_config_strap, code} = {p, 1'b1, s, c};
    {bridge_clock_select, bridge_role_select, local_gp_line_5} = b;
    bridge_clock_range_select = !b[0];
    if (p && clockEnable)
      e = {m, expF(m), b[2] ? 3'h1 : b[1] ? 3'h4 : 3'h2, !b[2] && b[0]};
    q.push_back(e);
    repeat (3) @(posedge clock);
    #1 {power_on_reset, hard_reset} = 2'b00;
    repeat (3) @(posedge clock);
  endtask
  task automatic give_verdict(input int t);
    numErrors += t;
    $display("checks %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clock)
  begin
    #2;
    if (++cycles > 3000)
      give_verdict(1);
    if (configValid === 1'b1 && lastValid !== 1'b1)
      chk("config", q.pop_front(), got);
    lastValid = configValid;
  end
  initial
  begin
    {rst_n, reset_config_strap, code, bridge_clock_select, bridge_role_select} = '0;
    {power_on_reset, hard_reset, clockEnable, bridge_clock_range_select, local_gp_line_5} = 5'h1c;
    repeat (20) @(posedge clock);
    #1 rst_n = 1;
    for (int i = 0; i < 128; i++)
      cfg(7'(i), 1'b1, 3'h4, 1'b1);
    $display("extended codes done");
    for (int i = 0; i < 12; i++)
    begin
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      cfg({rnd[6:3], 3'(i)}, i > 7, {i < 8, 2'(i)}, 1'b1);
    end
    $display("basic and bridge codes done");
    cfg(~code, 1'b1, 3'h2, 1'b0);
    #2 chk("held", q.pop_front(), got);
    $display("resample without power-on done");
    @(posedge clock) #1 clockEnable = 0;
    cfg(~code, 1'b1, 3'h1, 1'b1);
    #2 chk("frozen", q.pop_front(), got);
    $display("frozen clock enable done");
    @(posedge clock) #1 clockEnable = 1;
    // source keeps limits: 66 MHz in, cpm and core both 2.5, 166 MHz each
    cfg(7'h34, 1'b1, 3'h4, 1'b1);
    $display("in-limit code done");
    give_verdict(0);
  end
endmodule
